// [design/asop_core.sv]
// Sample strobe capture, error correction and five-stage output pipeline.
// Assumes coarse/fine/overrange results arrive from analog front end logic
// on the sample strobe pin; the strobe pin is synchronised to clk_sys.
//
// Function
// - Capture input, start conversion each strobe rise
// - Error-correct coarse/fine into one 9-bit word
// - Output word updates on strobe rise only
// - Output word lags its sample five strobes
// - Overrange clamps output to all ones/zeros
// - First in-range strobe repeats clamp code; valid conversions resume 2 clocks later
// - Below 1.5 MSPS hold stage tracks only
// - Hold mode entered on strobe rising edge
// - MSB on highest bit, LSB on bit zero
`timescale 1ns/1ps
`default_nettype none
module asop_core #(
   parameter int PIPE = asop_pkg::PIPE_DEPTH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sample_strobe,
   input wire asop_pkg::asop_sample_t front_result,
   output logic [asop_pkg::WORD_W-1:0] sample_word,
   output logic hold_active,
   output logic track_only,
   output logic rate_low,
   output logic pipe_flushed
);
   import asop_pkg::*;

   asop_state_t s_q;
   asop_state_t s_d;
   logic strobe_rise;
   logic [WORD_W-1:0] corrected;
   logic [WORD_W:0] sum_wide;

   ////////////////////////////////////////////////////////////////////////
   // Error correction: coarse weighs top bits, fine overlaps by one bit
   always_comb begin
      sum_wide = {1'b0, front_result.coarse, 4'h0}
         + {5'h00, front_result.fine}
         - {6'h00, 4'h8};
      if (sum_wide[WORD_W]) begin
         // Negative borrow from the overlap saturates low
         corrected = (front_result.coarse == 5'h00) ? CODE_ZERO : CODE_FULL;
      end else begin
         corrected = sum_wide[WORD_W-1:0];
      end
   end

   // Only the second and third stages are read; the first is metastable
   assign strobe_rise = s_q.strobe_sync[1] & ~s_q.strobe_sync[2];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.strobe_sync = {s_q.strobe_sync[1:0], sample_strobe};
      if (s_q.gap_cnt != {GAP_W{1'b1}}) begin
         s_d.gap_cnt = s_q.gap_cnt + 8'h01;
      end
      // Long strobe gap means the strobe has stopped or slowed
      if (32'(s_q.gap_cnt) > TRACK_ONLY_CYC) begin
         s_d.track_only = 1'b1;
         s_d.hold_active = 1'b0;
         s_d.flush_cnt = 3'h0;
      end
      if (32'(s_q.gap_cnt) > SLOW_CYC) begin
         s_d.rate_low = 1'b1;
      end
      if (s_q.mode == ASOP_RECOVER) begin
         if (s_q.recover_cnt != 4'h0) begin
            s_d.recover_cnt = s_q.recover_cnt - 4'h1;
         end else begin
            s_d.mode = ASOP_NORMAL;
         end
      end
      if (strobe_rise) begin
         s_d.gap_cnt = '0;
         s_d.track_only = 1'b0;
         s_d.rate_low = 32'(s_q.gap_cnt) > SLOW_CYC;
         s_d.hold_active = 1'b1;
         // New sample enters stage 0, older ones advance
         for (int i = PIPE - 1; i > 0; i--) begin
            s_d.pipe[i] = s_q.pipe[i-1];
         end
         s_d.pipe[0].valid = 1'b1;
         if (front_result.over_hi || front_result.over_lo) begin
            s_d.mode = ASOP_CLAMP;
            s_d.pipe[0].word = front_result.over_hi ? CODE_FULL : CODE_ZERO;
         end else if (s_q.mode == ASOP_CLAMP) begin
            s_d.mode = ASOP_RECOVER;
            s_d.recover_cnt = 4'(RECOVER_CYC);
            s_d.pipe[0].word = s_q.pipe[0].word;
         end else if (s_q.mode == ASOP_RECOVER) begin
            // Front end still settling; repeat the clamped code
            s_d.pipe[0].word = s_q.pipe[0].word;
         end else begin
            s_d.pipe[0].word = corrected;
         end
         s_d.sample_word = s_q.pipe[PIPE-1].word;
         if (s_q.flush_cnt != 3'(PIPE)) begin
            s_d.flush_cnt = s_q.flush_cnt + 3'h1;
         end
      end
      if (srst) begin
         s_d = '0;
         s_d.mode = ASOP_NORMAL;
         s_d.track_only = 1'b1;
         s_d.rate_low = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Word is held between strobe rises, since only strobe_rise loads it
   assign sample_word = s_q.sample_word;
   assign hold_active = s_q.hold_active;
   assign track_only = s_q.track_only;
   assign rate_low = s_q.rate_low;
   // Advisory for the capturer; flushed after five strobes since a stop
   assign pipe_flushed = (s_q.flush_cnt == 3'(PIPE));

endmodule : asop_core
`default_nettype wire

// [design/asop_pkg.sv]
// Package for the converter sample and output pipeline.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
package asop_pkg;

   localparam int WORD_W = 9;
   localparam int COARSE_W = 5;
   localparam int FINE_W = 5;
   localparam int PIPE_DEPTH = 5;
   localparam int CLK_PERIOD_PS = 40000;
   // Recovery after an overrange episode, in ns
   localparam int RECOVER_NS = 10;
   localparam int RECOVER_CYC_RAW = (RECOVER_NS * 1000) / CLK_PERIOD_PS;
   localparam int RECOVER_CYC = (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;
   // Rate limits, in samples per second
   localparam int MIN_GUAR_SPS = 3000000;
   localparam int TRACK_ONLY_SPS = 1500000;
   localparam int CLK_HZ = 25000000;
   // Longest strobe period, in clocks, before track-only (rounded down)
   localparam int TRACK_ONLY_CYC = CLK_HZ / TRACK_ONLY_SPS;
   localparam int SLOW_CYC = CLK_HZ / MIN_GUAR_SPS;
   localparam int GAP_W = 8;
   localparam logic [WORD_W-1:0] CODE_ZERO = 9'h000;
   localparam logic [WORD_W-1:0] CODE_FULL = 9'h1FF;

   typedef struct packed {
      logic [COARSE_W-1:0] coarse;
      logic [FINE_W-1:0] fine;
      logic over_hi;
      logic over_lo;
   } asop_sample_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic valid;
   } asop_stage_t;

   typedef enum logic [1:0] {
      ASOP_NORMAL,
      ASOP_CLAMP,
      ASOP_RECOVER
   } asop_mode_t;

   typedef struct packed {
      logic [2:0] strobe_sync;
      asop_stage_t [PIPE_DEPTH-1:0] pipe;
      logic [WORD_W-1:0] sample_word;
      logic [GAP_W-1:0] gap_cnt;
      logic track_only;
      logic rate_low;
      logic [2:0] flush_cnt;
      asop_mode_t mode;
      logic [3:0] recover_cnt;
      logic hold_active;
   } asop_state_t;

endpackage : asop_pkg

// [verification/asop_properties.sv]
// Port checker for the sample output pipeline.
// Assumes one clk_sys domain with synchronous srst.
`timescale 1ns/1ps
`default_nettype none
module asop_properties (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sample_strobe,
   input wire asop_pkg::asop_sample_t front_result,
   input wire logic [asop_pkg::WORD_W-1:0] sample_word,
   input wire logic hold_active,
   input wire logic track_only,
   input wire logic rate_low,
   input wire logic pipe_flushed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic [3:0] since_q;
   // Cycles since strobe last seen high, saturating
   always_ff @(posedge clk_sys)
      since_q <= (srst || !sample_strobe) ? (srst ? 4'hF : since_q + {3'h0,
         since_q != 4'hF}) : 4'h0;
   a_word_steady: assert property ($changed(sample_word) && !$past(srst)
      |-> since_q < 4'h6) else $error("word moved without strobe");
   a_reset_vals: assert property (disable iff (1'b0) srst |=> sample_word ==
      9'h000 && track_only && rate_low && !pipe_flushed && !hold_active)
      else $error("bad reset state");
   a_rate_order: assert property (track_only |-> rate_low)
      else $error("track without slow rate");
   a_hold_rise: assert property ($rose(sample_strobe) |-> ##[1:6] hold_active)
      else $error("hold not entered");
   a_slow_track: assert property ($stable(sample_strobe) [*8] ##1
      $stable(sample_strobe) [*8] ##1 $stable(sample_strobe) [*5]
      |-> ##[0:6] track_only) else $error("no track on stop");
   a_flush_hold: assert property ($rose(pipe_flushed) |-> hold_active &&
      $past(hold_active, 8)) else $error("flush too early");
   a_track_fall: assert property ($fell(track_only) |-> ##[0:2] hold_active)
      else $error("track left idle");
   a_stop_flush: assert property ($rose(track_only) |-> ##[0:2] !pipe_flushed)
      else $error("flush kept on stop");
endmodule : asop_properties
bind asop_core asop_properties u_props (.clk_sys(clk_sys), .srst(srst),
   .sample_strobe(sample_strobe), .front_result(front_result),
   .sample_word(sample_word), .hold_active(hold_active),
   .track_only(track_only), .rate_low(rate_low), .pipe_flushed(pipe_flushed));
`default_nettype wire

// [verification/asop_strobe_model.sv]
// Far-side strobe source; finishes a high phase before idling low.
// Assumes the bench sets half period in clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module asop_strobe_model (
   input wire logic clk_sys,
   input wire logic run,
   input wire logic [3:0] half,
   output logic sample_strobe,
   output int rises
);
   int cnt = 0;
   initial sample_strobe = 1'b0;
   initial rises = 0;
   // Idle low outside bursts; pulses kept whole
   always @(posedge clk_sys) begin
      #1;
      if (run || sample_strobe) begin
         cnt = cnt + 1;
         if (cnt >= half) begin
            cnt = 0;
            sample_strobe = !sample_strobe;
            rises = rises + sample_strobe;
         end
      end
   end
endmodule : asop_strobe_model
`default_nettype wire

// [verification/asop_core_bench.sv]
// Self-checking bench for the sample output pipeline.
// Assumes the strobe model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module asop_core_bench;
   import asop_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic run = 1'b0;
   logic [3:0] half = 4'h2;
   logic sample_strobe, hold_active, track_only, rate_low, pipe_flushed;
   int rises;
   asop_sample_t front_result = '0;
   logic [WORD_W-1:0] sample_word;
   int err_total = 0;
   int tests_run = 0;
   always #20 clk_sys = ~clk_sys;
   asop_strobe_model u_model (.clk_sys(clk_sys), .run(run), .half(half),
      .sample_strobe(sample_strobe), .rises(rises));
   asop_core dut (.clk_sys(clk_sys), .srst(srst), .sample_strobe(sample_strobe),
      .front_result(front_result), .sample_word(sample_word),
      .hold_active(hold_active), .track_only(track_only), .rate_low(rate_low),
      .pipe_flushed(pipe_flushed));
   task automatic chk(input string what, input logic [8:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic feed(input logic [4:0] c, f, input logic hi, lo, input int n);
      int goal;
      @(posedge clk_sys);
      #2 front_result = '{c, f, hi, lo};
      goal = rises + n;
      run = 1'b1;
      while (rises < goal)
         @(posedge clk_sys);
      #2 run = 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : feed
   task automatic results();
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   initial begin
      repeat (2000) @(posedge clk_sys);
      err_total++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      #2 srst = 1'b0;
      chk("flushed", 9'h000, pipe_flushed);
      feed(5'h05, 5'h08, 1'b0, 1'b0, 8);
      chk("word", 9'h050, sample_word);
      chk("flushed", 9'h001, pipe_flushed);
      chk("rate", 9'h000, rate_low);
      chk("hold", 9'h001, hold_active);
      feed(5'h10, 5'h08, 1'b0, 1'b0, 5);
      chk("lag", 9'h050, sample_word);
      feed(5'h10, 5'h08, 1'b0, 1'b0, 1);
      chk("msb", 9'h100, sample_word);
      feed(5'h03, 5'h00, 1'b1, 1'b0, 6);
      chk("high", 9'h1FF, sample_word);
      feed(5'h03, 5'h00, 1'b0, 1'b1, 6);
      chk("low", 9'h000, sample_word);
      feed(5'h03, 5'h0F, 1'b0, 1'b0, 7);
      chk("resume", 9'h037, sample_word);
      repeat (24) @(posedge clk_sys);
      chk("track", 9'h001, track_only);
      chk("stale", 9'h000, pipe_flushed);
      chk("idle", 9'h000, hold_active);
      #2 half = 4'h6;
      run = 1'b1;
      repeat (60) @(posedge clk_sys);
      chk("slow", 9'h001, rate_low);
      chk("notrack", 9'h000, track_only);
      results();
   end
endmodule : asop_core_bench
`default_nettype wire
